// File: design/ces_exception_seq.sv
// Functional notes
// - reset pin low halts and holds state
// - reset leaves on-chip RAM untouched
// - latch mode pins on reset release
// - reset clears trace, mask set seven
// - block interrupts until first instruction done
// - minimum mode: PC from word zero
// - maximum mode: code page, then PC
// - stack pointer never set by reset
// - load-control defers interrupts one instruction
// - address error clears trace, keeps mask
// - prefetch from register field faults
// - odd word access faults
// - single-chip off-chip access faults
// - single-chip disabled RAM access faults
// - trace flag set: trace each instruction
// - trace pushes T set, then clears
// - address error overrides trace after return
// - accept priority above mask; NMI eight
// - steer to transfer controller or CPU
// - CPU interrupt clears trace, raises mask
// - priority reset, address error, trace, interrupt
// - push state, clear trace, fetch vector
`default_nettype none
module ces_exception_seq
   import ces_pkg::*;
(
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   // pins
   input  wire logic                 ext_reset_pin_n,
   input  wire logic [2:0]           mode_select_pins,
   // cpu core
   input  wire logic                 insnDone,
   input  wire logic                 insnDefer,
   input  wire logic                 srWrEn,
   input  wire logic [15:0]          srWrData,
   input  wire ces_acc_t             busAcc,
   input  wire logic                 pushDone,
   input  wire logic [15:0]          vecRdData,
   input  wire logic                 vecRdValid,
   output logic                      cpuResetHold,
   output logic                      periphResetHold,
   output logic                      cpuStall,
   output logic [15:0]               statusWord,
   output logic                      pushReq,
   output logic [15:0]               pushSr,
   output logic                      pushCp,
   output logic                      vecRdReq,
   output logic [15:0]               vecRdAddr,
   output logic                      pcLoad,
   output logic [15:0]               pcValue,
   output logic                      cpLoad,
   output logic [7:0]                cpValue,
   // interrupt sources
   input  wire logic                 nmiReq,
   input  wire logic [NUM_SRC-1:0]   intReq,
   output logic                      nmiAck,
   output logic [NUM_SRC-1:0]        intAck,
   // transfer controller
   output logic                      dtcStart,
   output logic [1:0]                dtcSrc,
   input  wire logic                 dtcDone,
   // axi4-lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);

   function automatic logic modeIn(input logic [7:0] set, input logic [2:0] mode);
      modeIn = set[mode];
   endfunction

   function automatic logic [15:0] vecScale(input logic [15:0] v, input logic maxMode);
      vecScale = maxMode ? {v[14:0], 1'b0} : v;
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      wmerge = r;
   endfunction

   // pin synchronisers
   logic [1:0]  rstPinMeta_ff;
   logic [2:0]  modeMeta_ff;
   logic [2:0]  modeSync_ff;
   logic        pinHigh;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rstPinMeta_ff <= 2'h0;
         modeMeta_ff   <= 3'h0;
         modeSync_ff   <= 3'h0;
      end else begin
         rstPinMeta_ff <= {rstPinMeta_ff[0], ext_reset_pin_n};
         modeMeta_ff   <= mode_select_pins;
         modeSync_ff   <= modeMeta_ff;
      end
   end
   // two-stage delay relies on the minimum low time on the pin
   // pin low long enough
   assign pinHigh = rstPinMeta_ff[1];

   // sequencer state
   ces_state_t  state_ff, nxt_state;
   logic [2:0]  modeBits_ff, nxt_modeBits;
   logic [15:0] sr_ff, nxt_sr;
   logic        intBlock_ff, nxt_intBlock;
   logic        aerrPend_ff, nxt_aerrPend;
   logic [15:0] vecBase_ff, nxt_vecBase;
   logic        vecRdReq_ff, nxt_vecRdReq;
   logic [15:0] vecRdAddr_ff, nxt_vecRdAddr;
   logic        pushReq_ff, nxt_pushReq;
   logic [15:0] pushSr_ff, nxt_pushSr;
   logic        pcLoad_ff, nxt_pcLoad;
   logic [15:0] pcValue_ff, nxt_pcValue;
   logic        cpLoad_ff, nxt_cpLoad;
   logic [7:0]  cpValue_ff, nxt_cpValue;
   logic        nmiAck_ff, nxt_nmiAck;
   logic [NUM_SRC-1:0] intAck_ff, nxt_intAck;
   logic        dtcStart_ff, nxt_dtcStart;
   logic [1:0]  dtcSrc_ff, nxt_dtcSrc;

   // software registers
   logic        ramEn_ff, nxt_ramEn;
   logic [11:0] prio_ff, nxt_prio;
   logic [3:0]  xferEn_ff, nxt_xferEn;

   logic        maxMode;
   logic        singleChip;
   logic        errNow;
   logic [2:0]  curMask;
   logic        srcFound;
   logic [1:0]  srcIdx;
   logic [2:0]  srcLvl;

   assign maxMode    = modeIn(MAX_MODE_SET, modeBits_ff);
   assign singleChip = modeIn(SINGLE_CHIP_SET, modeBits_ff);
   assign curMask    = sr_ff[SR_MASK_LSB +: 3];

   always_comb begin
      errNow = 1'b0;
      if (busAcc.valid) begin
         if (busAcc.prefetch && busAcc.addr >= REGFIELD_LO) begin
            errNow = 1'b1;
         end
         if (busAcc.word && busAcc.addr[0]) begin
            errNow = 1'b1;
         end
         if (singleChip && busAcc.addr >= OFFCHIP_LO && busAcc.addr <= OFFCHIP_HI) begin
            errNow = 1'b1;
         end
         if (singleChip && !ramEn_ff && busAcc.addr >= RAM_LO && busAcc.addr <= RAM_HI) begin
            errNow = 1'b1;
         end
      end
   end

   // highest level above the mask; lower index wins a tie
   always_comb begin
      srcFound = 1'b0;
      srcIdx   = 2'h0;
      srcLvl   = 3'h0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (intReq[i] && prio_ff[PRIO_W*i +: PRIO_W] > curMask &&
             (!srcFound || prio_ff[PRIO_W*i +: PRIO_W] > srcLvl)) begin
            srcFound = 1'b1;
            srcIdx   = 2'(i);
            srcLvl   = prio_ff[PRIO_W*i +: PRIO_W];
         end
      end
   end

   always_comb begin
      nxt_state     = state_ff;
      nxt_modeBits  = modeBits_ff;
      nxt_sr        = sr_ff;
      nxt_intBlock  = intBlock_ff;
      nxt_aerrPend  = aerrPend_ff;
      nxt_vecBase   = vecBase_ff;
      nxt_vecRdReq  = vecRdReq_ff;
      nxt_vecRdAddr = vecRdAddr_ff;
      nxt_pushReq   = pushReq_ff;
      nxt_pushSr    = pushSr_ff;
      nxt_pcLoad    = 1'b0;
      nxt_pcValue   = pcValue_ff;
      nxt_cpLoad    = 1'b0;
      nxt_cpValue   = cpValue_ff;
      nxt_nmiAck    = 1'b0;
      nxt_intAck    = '0;
      nxt_dtcStart  = 1'b0;
      nxt_dtcSrc    = dtcSrc_ff;
      if (state_ff == ST_RUN && errNow) begin
         nxt_aerrPend = 1'b1;
      end
      if (state_ff == ST_RUN && srWrEn) begin
         nxt_sr = srWrData;
      end
      case (state_ff)
         ST_HOLD: begin
            if (pinHigh) begin
               nxt_modeBits  = modeSync_ff;
               nxt_sr        = 16'h0000;
               nxt_sr[SR_MASK_LSB +: 3] = MASK_ALL;
               nxt_intBlock  = 1'b1;
               nxt_vecBase   = VEC_RESET;
               nxt_vecRdAddr = VEC_RESET;
               nxt_vecRdReq  = 1'b1;
               nxt_state     = ST_VEC0;
            end
         end
         ST_VEC0: begin
            if (vecRdValid) begin
               if (maxMode) begin
                  nxt_cpValue   = vecRdData[7:0];
                  nxt_cpLoad    = 1'b1;
                  nxt_vecRdAddr = 16'(vecBase_ff + VEC_STEP);
                  nxt_state     = ST_VEC1;
               end else begin
                  nxt_pcValue  = vecRdData;
                  nxt_pcLoad   = 1'b1;
                  nxt_vecRdReq = 1'b0;
                  nxt_state    = ST_RUN;
               end
            end
         end
         ST_VEC1: begin
            if (vecRdValid) begin
               nxt_pcValue  = vecRdData;
               nxt_pcLoad   = 1'b1;
               nxt_vecRdReq = 1'b0;
               nxt_state    = ST_RUN;
            end
         end
         ST_RUN: begin
            if (insnDone) begin
               // load-control blocks only its own end
               nxt_intBlock = 1'b0;
               if (aerrPend_ff || errNow) begin
                  nxt_aerrPend = 1'b0;
                  nxt_pushSr   = (srWrEn) ? srWrData : sr_ff;
                  nxt_sr       = (srWrEn) ? srWrData : sr_ff;
                  nxt_sr[SR_T_BIT] = 1'b0;
                  nxt_vecBase  = vecScale(VEC_ADDR_ERR, maxMode);
                  nxt_pushReq  = 1'b1;
                  nxt_state    = ST_PUSH;
               end else if (sr_ff[SR_T_BIT]) begin
                  nxt_pushSr   = sr_ff;
                  nxt_sr[SR_T_BIT] = 1'b0;
                  nxt_vecBase  = vecScale(VEC_TRACE, maxMode);
                  nxt_pushReq  = 1'b1;
                  nxt_state    = ST_PUSH;
               end else if (!intBlock_ff && !insnDefer && (nmiReq || srcFound)) begin
                  if (nmiReq) begin
                     nxt_nmiAck   = 1'b1;
                     nxt_pushSr   = sr_ff;
                     nxt_sr[SR_T_BIT] = 1'b0;
                     nxt_sr[SR_MASK_LSB +: 3] = MASK_ALL;
                     nxt_vecBase  = vecScale(VEC_NMI, maxMode);
                     nxt_pushReq  = 1'b1;
                     nxt_state    = ST_PUSH;
                  end else if (xferEn_ff[srcIdx]) begin
                     nxt_intAck[srcIdx] = 1'b1;
                     nxt_dtcStart = 1'b1;
                     nxt_dtcSrc   = srcIdx;
                     nxt_state    = ST_XFER;
                  end else begin
                     nxt_intAck[srcIdx] = 1'b1;
                     nxt_pushSr   = sr_ff;
                     nxt_sr[SR_T_BIT] = 1'b0;
                     nxt_sr[SR_MASK_LSB +: 3] = srcLvl;
                     nxt_vecBase  = vecScale(16'(VEC_IRQ_BASE | {13'h0000, srcIdx, 1'b0}), maxMode);
                     nxt_pushReq  = 1'b1;
                     nxt_state    = ST_PUSH;
                  end
               end
            end
         end
         ST_PUSH: begin
            if (pushDone) begin
               nxt_pushReq   = 1'b0;
               nxt_vecRdAddr = vecBase_ff;
               nxt_vecRdReq  = 1'b1;
               nxt_state     = ST_VEC0;
            end
         end
         ST_XFER: begin
            if (dtcDone) begin
               // one instruction runs before the next interrupt
               nxt_intBlock = 1'b1;
               nxt_state    = ST_RUN;
            end
         end
         default: begin
            nxt_state = ST_HOLD;
         end
      endcase
      if (!pinHigh) begin
         nxt_state    = ST_HOLD;
         nxt_sr       = 16'h0000;
         nxt_sr[SR_MASK_LSB +: 3] = MASK_ALL;
         nxt_intBlock = 1'b1;
         nxt_aerrPend = 1'b0;
         nxt_vecRdReq = 1'b0;
         nxt_pushReq  = 1'b0;
         nxt_intAck   = '0;
         nxt_nmiAck   = 1'b0;
         nxt_dtcStart = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff     <= ST_HOLD;
         modeBits_ff  <= MODE_RESET;
         sr_ff        <= 16'h0700;
         intBlock_ff  <= 1'b1;
         aerrPend_ff  <= 1'b0;
         vecBase_ff   <= VEC_RESET;
         vecRdReq_ff  <= 1'b0;
         vecRdAddr_ff <= VEC_RESET;
         pushReq_ff   <= 1'b0;
         pushSr_ff    <= 16'h0000;
         pcLoad_ff    <= 1'b0;
         pcValue_ff   <= 16'h0000;
         cpLoad_ff    <= 1'b0;
         cpValue_ff   <= 8'h00;
         nmiAck_ff    <= 1'b0;
         intAck_ff    <= '0;
         dtcStart_ff  <= 1'b0;
         dtcSrc_ff    <= 2'h0;
      end else begin
         state_ff     <= nxt_state;
         modeBits_ff  <= nxt_modeBits;
         sr_ff        <= nxt_sr;
         intBlock_ff  <= nxt_intBlock;
         aerrPend_ff  <= nxt_aerrPend;
         vecBase_ff   <= nxt_vecBase;
         vecRdReq_ff  <= nxt_vecRdReq;
         vecRdAddr_ff <= nxt_vecRdAddr;
         pushReq_ff   <= nxt_pushReq;
         pushSr_ff    <= nxt_pushSr;
         pcLoad_ff    <= nxt_pcLoad;
         pcValue_ff   <= nxt_pcValue;
         cpLoad_ff    <= nxt_cpLoad;
         cpValue_ff   <= nxt_cpValue;
         nmiAck_ff    <= nxt_nmiAck;
         intAck_ff    <= nxt_intAck;
         dtcStart_ff  <= nxt_dtcStart;
         dtcSrc_ff    <= nxt_dtcSrc;
      end
   end

   assign cpuResetHold    = (state_ff == ST_HOLD);
   assign periphResetHold = !pinHigh;
   assign cpuStall        = (state_ff == ST_XFER);
   assign statusWord      = sr_ff;
   assign pushReq         = pushReq_ff;
   assign pushSr          = pushSr_ff;
   assign pushCp          = maxMode;
   assign vecRdReq        = vecRdReq_ff;
   assign vecRdAddr       = vecRdAddr_ff;
   assign pcLoad          = pcLoad_ff;
   assign pcValue         = pcValue_ff;
   assign cpLoad          = cpLoad_ff;
   assign cpValue         = cpValue_ff;
   assign nmiAck          = nmiAck_ff;
   assign intAck          = intAck_ff;
   assign dtcStart        = dtcStart_ff;
   assign dtcSrc          = dtcSrc_ff;

   // register bus; one write and one read in flight
   logic        awHeld_ff, nxt_awHeld;
   logic [7:0]  awAddr_ff, nxt_awAddr;
   logic        wHeld_ff, nxt_wHeld;
   logic [31:0] wData_ff, nxt_wData;
   logic [3:0]  wStrb_ff, nxt_wStrb;
   logic        bvalid_ff, nxt_bvalid;
   logic [1:0]  bresp_ff, nxt_bresp;
   logic        rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0]  rresp_ff, nxt_rresp;

   assign s_axi_awready = !awHeld_ff && !bvalid_ff;
   assign s_axi_wready  = !wHeld_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   always_comb begin
      nxt_awHeld = awHeld_ff;
      nxt_awAddr = awAddr_ff;
      nxt_wHeld  = wHeld_ff;
      nxt_wData  = wData_ff;
      nxt_wStrb  = wStrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp  = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata  = rdata_ff;
      nxt_rresp  = rresp_ff;
      nxt_ramEn  = ramEn_ff;
      nxt_prio   = prio_ff;
      nxt_xferEn = xferEn_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_awHeld = 1'b1;
         nxt_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_wHeld = 1'b1;
         nxt_wData = s_axi_wdata;
         nxt_wStrb = s_axi_wstrb;
      end
      if (awHeld_ff && wHeld_ff) begin
         nxt_awHeld = 1'b0;
         nxt_wHeld  = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp  = RESP_OKAY;
         case (awAddr_ff)
            REG_MODE, REG_STAT: begin
            end
            REG_RAMCTL: begin
               if (wStrb_ff[0]) begin
                  nxt_ramEn = wData_ff[0];
               end
            end
            REG_PRIO: begin
               nxt_prio = 12'(wmerge({20'h00000, prio_ff}, wData_ff, wStrb_ff));
            end
            REG_XFER: begin
               nxt_xferEn = 4'(wmerge({28'h0000000, xferEn_ff}, wData_ff, wStrb_ff));
            end
            default: begin
               nxt_bresp = RESP_SLVERR;
            end
         endcase
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = RESP_OKAY;
         case (s_axi_araddr)
            REG_MODE:   nxt_rdata = {29'h00000000, modeBits_ff};
            REG_RAMCTL: nxt_rdata = {31'h00000000, ramEn_ff};
            REG_PRIO:   nxt_rdata = {20'h00000, prio_ff};
            REG_XFER:   nxt_rdata = {28'h0000000, xferEn_ff};
            REG_STAT:   nxt_rdata = {11'h000, state_ff, intBlock_ff, aerrPend_ff, sr_ff};
            default: begin
               nxt_rdata = 32'h00000000;
               nxt_rresp = RESP_SLVERR;
            end
         endcase
      end
      if (!pinHigh) begin
         nxt_ramEn  = RAMEN_RESET;
         nxt_prio   = PRIO_RESET;
         nxt_xferEn = XFER_RESET;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         awHeld_ff <= 1'b0;
         awAddr_ff <= 8'h00;
         wHeld_ff  <= 1'b0;
         wData_ff  <= 32'h00000000;
         wStrb_ff  <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= RESP_OKAY;
         ramEn_ff  <= RAMEN_RESET;
         prio_ff   <= PRIO_RESET;
         xferEn_ff <= XFER_RESET;
      end else begin
         awHeld_ff <= nxt_awHeld;
         awAddr_ff <= nxt_awAddr;
         wHeld_ff  <= nxt_wHeld;
         wData_ff  <= nxt_wData;
         wStrb_ff  <= nxt_wStrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff  <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rresp;
         ramEn_ff  <= nxt_ramEn;
         prio_ff   <= nxt_prio;
         xferEn_ff <= nxt_xferEn;
      end
   end

endmodule
`default_nettype wire

// File: design/ces_pkg.sv
`default_nettype none
package ces_pkg;
   // request sources: 0 and 1 are the two external requests, 2..3 internal
   localparam int NUM_SRC = 4;
   localparam int PRIO_W  = 3;

   // register offsets (byte addresses)
   localparam logic [7:0] REG_MODE   = 8'h00;
   localparam logic [7:0] REG_RAMCTL = 8'h04;
   localparam logic [7:0] REG_PRIO   = 8'h08;
   localparam logic [7:0] REG_XFER   = 8'h0C;
   localparam logic [7:0] REG_STAT   = 8'h10;

   // field positions and reset values
   localparam int         SR_T_BIT     = 15;
   localparam int         SR_MASK_LSB  = 8;
   localparam logic [2:0] MASK_ALL     = 3'h7;
   localparam logic       RAMEN_RESET  = 1'b1;
   localparam logic [11:0] PRIO_RESET  = 12'h000;
   localparam logic [3:0] XFER_RESET   = 4'h0;
   localparam logic [2:0] MODE_RESET   = 3'h0;

   // mode decode, one bit per latched mode value
   localparam logic [7:0] MAX_MODE_SET    = 8'h98;
   localparam logic [7:0] SINGLE_CHIP_SET = 8'hC0;

   // vector addresses in minimum mode; maximum mode doubles them
   localparam logic [15:0] VEC_RESET    = 16'h0000;
   localparam logic [15:0] VEC_ADDR_ERR = 16'h0010;
   localparam logic [15:0] VEC_TRACE    = 16'h0012;
   localparam logic [15:0] VEC_NMI      = 16'h0016;
   localparam logic [15:0] VEC_IRQ_BASE = 16'h0040;
   localparam logic [15:0] VEC_STEP     = 16'h0002;

   // address map bounds
   localparam logic [15:0] REGFIELD_LO = 16'hFF80;
   localparam logic [15:0] OFFCHIP_LO  = 16'h8000;
   localparam logic [15:0] OFFCHIP_HI  = 16'hFB7F;
   localparam logic [15:0] RAM_LO      = 16'hFB80;
   localparam logic [15:0] RAM_HI      = 16'hFF7F;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_HOLD = 3'b000,
      ST_VEC0 = 3'b001,
      ST_VEC1 = 3'b010,
      ST_RUN  = 3'b011,
      ST_PUSH = 3'b100,
      ST_XFER = 3'b101
   } ces_state_t;

   typedef struct packed {
      logic        valid;
      logic        prefetch;
      logic        word;
      logic [15:0] addr;
   } ces_acc_t;
endpackage
`default_nettype wire

// File: tb/ces_cpu_model.sv
`default_nettype none
module ces_cpu_model (
   input wire logic        mclk, vecRdReq, pushReq, cpuStall,
   input wire logic [1:0]  lat,
   input wire logic [15:0] vecRdAddr,
   output var logic        vecRdValid = 0, pushDone = 0, dtcDone = 0,
   output var logic [15:0] vecRdData = 0
);
   int n = 0;
   // one shared wait counter; lat sets prompt or slow answers
   always @(posedge mclk) begin
      n <= (vecRdReq && !vecRdValid || pushReq && !pushDone || cpuStall && !dtcDone) ? n + 1 : 0;
      vecRdValid <= vecRdReq && !vecRdValid && n == lat;
      pushDone <= pushReq && !pushDone && n == lat;
      dtcDone <= cpuStall && !dtcDone && n == lat;
      // idle bus flips so stale data never looks valid
      vecRdData <= (vecRdReq && n == lat) ? vecRdAddr ^ 16'hA5A5 : ~vecRdData;
   end
endmodule
`default_nettype wire

// File: tb/ces_exception_seq_checker.sv
`default_nettype none
module ces_exception_seq_checker import ces_pkg::*; (
   input wire logic               mclk, sys_rst, ext_reset_pin_n, cpuResetHold, cpuStall,
   input wire logic               pushReq, vecRdReq, vecRdValid, nmiAck, dtcStart,
   input wire logic [15:0]        statusWord, pushSr, vecRdAddr,
   input wire logic [NUM_SRC-1:0] intAck
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_hold; cpuResetHold |-> statusWord[15:8] == 8'h07; endproperty
   a_hold: assert property (p_hold) else $error("status word wrong in reset");
   property p_pin; !ext_reset_pin_n [*4] |-> cpuResetHold; endproperty
   a_pin: assert property (p_pin) else $error("pin low without hold");
   property p_vec; $fell(cpuResetHold) |-> vecRdReq && vecRdAddr == 16'h0000; endproperty
   a_vec: assert property (p_vec) else $error("reset vector fetch wrong");
   property p_push; $rose(pushReq) |-> !statusWord[15]; endproperty
   a_push: assert property (p_push) else $error("trace flag kept on push");
   property p_tpush; $rose(pushReq) && $past(statusWord[15]) |-> pushSr[15]; endproperty
   a_tpush: assert property (p_tpush) else $error("pushed trace flag lost");
   property p_stall; dtcStart |-> cpuStall && $onehot(intAck) && !nmiAck; endproperty
   a_stall: assert property (p_stall) else $error("transfer start wrong");
   property p_nmi; nmiAck |-> ##[0:2] statusWord[10:8] == 3'h7; endproperty
   a_nmi: assert property (p_nmi) else $error("mask not raised to seven");
   property p_vreq; vecRdReq && !vecRdValid |=> vecRdReq && $stable(vecRdAddr); endproperty
   a_vreq: assert property (p_vreq) else $error("vector request dropped");
endmodule
bind ces_exception_seq ces_exception_seq_checker ces_chk_inst (.*);
`default_nettype wire

// File: tb/ces_exception_seq_tb.sv
`default_nettype none
module ces_exception_seq_tb import ces_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, sys_rst = 1, ext_reset_pin_n = 0, insnDone = 0, insnDefer = 0, srWrEn = 0, nmiReq = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic cpuResetHold, periphResetHold, cpuStall, pushReq, pushCp, vecRdReq, pcLoad, cpLoad, nmiAck, dtcStart;
   logic pushDone, vecRdValid, dtcDone, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] dtcSrc, s_axi_bresp, s_axi_rresp, lat = 1;
   logic [2:0] mode_select_pins = 0;
   logic [3:0] intAck, intReq = 0, s_axi_wstrb = 4'hF;
   logic [7:0] cpValue, s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [15:0] statusWord, pushSr, vecRdAddr, pcValue, vecRdData, srWrData = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   ces_acc_t busAcc = '0;
   int err_count = 0, checks = 0, cyc = 0, pushes = 0;
   ces_exception_seq ces_exception_seq_inst (.*);
   ces_cpu_model ces_cpu_model_inst (.*);
   always #20 mclk = ~mclk;
   always @(posedge mclk) if (pushReq || dtcStart) pushes <= pushes + 1;
   task end_sim;
      if (err_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task tick;
      @(posedge mclk);
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         end_sim;
      end
   endtask
   task chk(input logic [33:0] s, e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      do begin
         tick;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [33:0] e);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do tick; while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do tick; while (!s_axi_rvalid);
      chk({s_axi_rresp, s_axi_rdata}, e);
      s_axi_rready <= 0;
   endtask
   task sr(input logic [15:0] v);
      srWrEn <= 1; srWrData <= v; tick; srWrEn <= 0;
   endtask
   // all ones as expected vector means no exception may start
   task exc(input ces_acc_t a, input logic d, input logic [15:0] v);
      int p;
      p = pushes;
      busAcc <= a; insnDefer <= d; insnDone <= 1; tick; busAcc <= '0; insnDefer <= 0; insnDone <= 0;
      if (v == 16'hFFFF) begin
         repeat (4) tick;
         chk(pushes - p, 0);
      end else begin
         while (!vecRdReq) tick;
         chk(vecRdAddr, v);
         while (!pcLoad) tick;
      end
   endtask
   initial begin
      repeat (6) tick; sys_rst <= 0;
      repeat (4) tick; ext_reset_pin_n <= 1;
      while (!pcLoad) tick; chk(pcValue, 16'hA5A5);
      chk(statusWord, 16'h0700);
      chk({periphResetHold, pushCp}, 0);
      rd(REG_MODE, 0);
      rd(8'h14, {RESP_SLVERR, 32'h0});
      nmiReq <= 1; exc('0, 0, 16'hFFFF);
      exc('0, 0, VEC_NMI); nmiReq <= 0;
      sr(16'h0200); wr(REG_PRIO, 2); intReq <= 1; exc('0, 0, 16'hFFFF);
      wr(REG_PRIO, 3); exc('0, 1, 16'hFFFF);
      exc('0, 0, VEC_IRQ_BASE); chk(statusWord, 16'h0300); intReq <= 0;
      wr(REG_XFER, 2); wr(REG_PRIO, 32'h28); lat <= 3; intReq <= 2; insnDone <= 1; tick; insnDone <= 0;
      while (!dtcStart) tick; chk(dtcSrc, 1); intReq <= 0;
      while (cpuStall) tick; lat <= 0;
      sr(16'h8300); exc('0, 0, VEC_TRACE); chk(statusWord, 16'h0300);
      sr(16'h8300); exc('{1, 1, 0, 16'hFF80}, 0, VEC_ADDR_ERR); chk(statusWord, 16'h0300);
      exc('{1, 0, 1, 16'h1001}, 0, VEC_ADDR_ERR); exc('{1, 0, 0, 16'h1001}, 0, 16'hFFFF);
      ext_reset_pin_n <= 0; mode_select_pins <= 7; repeat (7) tick; chk(periphResetHold, 1);
      ext_reset_pin_n <= 1;
      while (!cpLoad) tick; chk(cpValue, 8'hA5); while (!pcLoad) tick; chk(pcValue, 16'hA5A7);
      chk(pushCp, 1);
      rd(REG_MODE, 7); exc('{1, 0, 0, 16'h8000}, 0, 16'h0020);
      exc('{1, 0, 0, 16'hFF7F}, 0, 16'hFFFF); wr(REG_RAMCTL, 0); exc('{1, 0, 0, 16'hFB80}, 0, 16'h0020);
      end_sim;
   end
endmodule
`default_nettype wire
